// [sei_pkg.sv]
// Purpose: constants for the serial eeprom instruction port
// Assumes: 20 MHz system clock, shift clock sampled as a plain input
// Notes:   constants shared by the port and its word store
package sei_pkg;
  localparam int          SEI_WORD_BITS   = 16;        // word width
  localparam int          SEI_ADDR_BITS   = 8;         // larger part address width
  localparam int          SEI_OP_BITS     = 2;         // opcode width
  localparam int          SEI_HEAD_BITS   = SEI_OP_BITS + SEI_ADDR_BITS;
  localparam logic [1:0]  SEI_OP_READ     = 2'h2;      // opcode 10
  localparam logic [1:0]  SEI_OP_WRITE    = 2'h1;      // opcode 01
  localparam logic [1:0]  SEI_OP_ERASE    = 2'h3;      // opcode 11
  localparam logic [1:0]  SEI_OP_EXT      = 2'h0;      // opcode 00
  localparam logic [1:0]  SEI_EXT_ENABLE  = 2'h3;      // program_enable_cmd
  localparam logic [1:0]  SEI_EXT_BERASE  = 2'h2;      // bulk_erase_cmd
  localparam logic [1:0]  SEI_EXT_BWRITE  = 2'h1;      // bulk_write_cmd
  localparam logic [1:0]  SEI_EXT_DISABLE = 2'h0;      // program_disable_cmd
  localparam int          SEI_CLK_MHZ     = 20;        // system clock rate
  localparam int          SEI_PROG_US     = 15000;     // write cycle time in us
  localparam int          SEI_PROG_CYC    = SEI_PROG_US * SEI_CLK_MHZ;
  localparam logic [15:0] SEI_ERASED      = 16'hFFFF;  // erased word value
  typedef enum logic [4:0] {
    SEI_IDLE  = 5'h01,  // waiting for start bit
    SEI_HEAD  = 5'h02,  // shifting opcode and address
    SEI_DATA  = 5'h04,  // shifting sixteen data bits
    SEI_READ  = 5'h08,  // shifting read data out
    SEI_HOLD  = 5'h10   // instruction complete, waiting for select low
  } sei_state_type;
  typedef enum logic [2:0] {
    SEI_PG_NONE  = 3'h0,  // nothing pending
    SEI_PG_WRITE = 3'h1,  // single word write
    SEI_PG_ERASE = 3'h2,  // single word erase
    SEI_PG_BWR   = 3'h3,  // bulk write
    SEI_PG_BER   = 3'h4   // bulk erase
  } sei_prog_type;
endpackage : sei_pkg

// [sei_store.sv]
// Purpose: word array of the serial eeprom with registered read data
// Assumes: one access per clock, bulk fill done as a loop over words
// Notes:   bulk operations walk the array one word per clock
`timescale 1ns/1ps
`default_nettype none
module sei_store #(
  parameter int WORDS = 256,
  parameter int AW    = 8,
  parameter int DW    = 16
) (
  // clock
  input  wire logic          clk_sys,
  // access
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  initial begin
    if (WORDS > (1 << AW)) $error("sei_store: WORDS exceeds address range");
  end
  logic [DW-1:0] mem [WORDS];  // storage cells, no reset like real cells
  // write port and registered read port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : sei_store
`default_nettype wire

// [sei_port.sv]
// Purpose: serial instruction port and programming control
// Assumes: shift clock, select and serial input are asynchronous pins
// Notes:   programming is self timed; bulk ops sweep the array
`timescale 1ns/1ps
`default_nettype none
module sei_port
  import sei_pkg::*;
#(
  parameter int PROG_CYCLES = sei_pkg::SEI_PROG_CYC,  // self timed cycle length
  parameter int WORDS       = 256                     // words in the array
) (
  // system
  input  wire logic clk_sys,
  input  wire logic reset,
  // serial pins
  input  wire logic chip_select,
  input  wire logic shift_clock,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  // protection of larger parts
  input  wire logic protect_clear,
  input  wire logic [sei_pkg::SEI_ADDR_BITS-1:0] protect_addr
);
  import sei_pkg::*;
  localparam int AW = SEI_ADDR_BITS;
  initial begin
    if (PROG_CYCLES < 2) $error("sei_port: PROG_CYCLES too small");
    if (WORDS != (1 << AW)) $error("sei_port: WORDS must fill the address");
  end
  // two flip-flop synchronisers
  logic [2:0] sync1, sync2;
  logic       sk_prev;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1   <= 3'h0;
      sync2   <= 3'h0;
      sk_prev <= 1'b0;
    end else begin
      sync1   <= {chip_select, shift_clock, serial_in};
      sync2   <= sync1;
      sk_prev <= sync2[1];
    end
  end
  logic cs, din, sk_rise;
  assign cs      = sync2[2];
  assign din     = sync2[0];
  assign sk_rise = sync2[1] & ~sk_prev;  // rising shift clock edge
  // protection pins through two flip-flops; they are static settings, so a word
  // caught mid-change is harmless unless a write is judged in that very clock
  logic          prot_clr_meta, prot_clr;
  logic [AW-1:0] prot_addr_meta, prot_addr;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prot_clr_meta  <= 1'b0;
      prot_addr_meta <= '0;
      prot_clr       <= 1'b0;
      prot_addr      <= '0;
    end else begin
      prot_clr_meta  <= protect_clear;
      prot_addr_meta <= protect_addr;
      prot_clr       <= prot_clr_meta;
      prot_addr      <= prot_addr_meta;
    end
  end
  // state
  sei_state_type state, next_state;
  sei_prog_type  pend, next_pend;     // programming waiting for select low
  sei_prog_type  prog, next_prog;     // programming in progress
  logic [SEI_HEAD_BITS-1:0] head, next_head;    // opcode and address
  logic [SEI_WORD_BITS-1:0] shreg, next_shreg;  // data in or out
  logic [4:0]    cnt, next_cnt;       // bit counter
  logic          wen, next_wen;       // programming enabled
  logic [AW-1:0] paddr, next_paddr;   // program address or sweep index
  logic [SEI_WORD_BITS-1:0] pdata, next_pdata;
  logic [31:0]   ptime, next_ptime;   // self timed countdown
  logic          cs_prev;
  logic          dout, next_dout, oen, next_oen;
  logic          load_rd, next_load_rd;
  logic          wr_en;
  logic [SEI_WORD_BITS-1:0] rd_data;
  logic [1:0]    op;
  assign op = head[SEI_HEAD_BITS-1 -: 2];
  sei_store #(.WORDS(WORDS), .AW(AW), .DW(SEI_WORD_BITS)) u_store (
    .clk_sys (clk_sys),
    .wr_en   (wr_en),
    .wr_addr (paddr),
    .wr_data (pdata),
    .rd_addr (next_head[AW-1:0]),  // word ready when the load strobe follows
    .rd_data (rd_data)
  );
  // store writes once the timed count has run down; a bulk op stays there, one word a clock
  assign wr_en = (prog != SEI_PG_NONE) && (ptime == 32'h1);
  // next state of decoder and programming
  always_comb begin
    next_state   = state;
    next_pend    = pend;
    next_prog    = prog;
    next_head    = head;
    next_shreg   = shreg;
    next_cnt     = cnt;
    next_wen     = wen;
    next_paddr   = paddr;
    next_pdata   = pdata;
    next_ptime   = ptime;
    next_dout    = dout;
    next_oen     = oen;
    next_load_rd = 1'b0;
    // programming run: count down to one, then write; bulk ops sweep every word once
    if (prog != SEI_PG_NONE) begin
      if (!wr_en) begin
        next_ptime = ptime - 32'h1;
      end else begin
        next_paddr = paddr + 1'b1;
        if (prog == SEI_PG_WRITE || prog == SEI_PG_ERASE || paddr == AW'(WORDS - 1)) begin
          next_prog = SEI_PG_NONE;  // whole array or single word done
        end
      end
    end
    if (!cs) begin
      // select low: decoder reset, output released
      next_state = SEI_IDLE;
      next_oen   = 1'b1;
      next_cnt   = 5'h0;
      if (pend != SEI_PG_NONE && prog == SEI_PG_NONE) begin
        // programming begins on select falling
        next_prog  = pend;
        next_ptime = 32'(PROG_CYCLES);
        if (pend == SEI_PG_BWR || pend == SEI_PG_BER) begin
          next_paddr = '0;
        end
      end
      next_pend = SEI_PG_NONE;  // unfinished instruction aborted
    end else begin
      if (state == SEI_IDLE && prog != SEI_PG_NONE) begin
        next_oen  = 1'b0;  // busy shows low while programming
        next_dout = 1'b0;
      end else if (state == SEI_IDLE && !oen && prog == SEI_PG_NONE) begin
        next_dout = 1'b1;  // ready shows high
      end
      if (load_rd) begin
        next_shreg = rd_data;  // word into output shift register
      end
      if (sk_rise) begin
        case (state)
          SEI_IDLE: begin
            if (din) begin  // zero bits ignored until start bit
              next_state = SEI_HEAD;
              next_cnt   = 5'h0;
              next_oen   = 1'b1;
            end
          end
          SEI_HEAD: begin
            next_head = {head[SEI_HEAD_BITS-2:0], din};  // msb first
            next_cnt  = cnt + 5'h1;
            if (cnt == 5'(SEI_HEAD_BITS - 1)) begin
              next_cnt   = 5'h0;
              next_state = SEI_HOLD;
              // decode opcode and top address bits
              case (next_head[SEI_HEAD_BITS-1 -: 2])
                SEI_OP_READ: begin
                  next_state   = SEI_READ;  // allowed regardless of enable
                  next_oen     = 1'b0;
                  next_dout    = 1'b0;      // dummy zero bit
                  next_load_rd = 1'b1;
                end
                SEI_OP_WRITE: next_state = SEI_DATA;  // sixteen data bits follow
                SEI_OP_ERASE: begin
                  if (wen) begin  // refused while disabled
                    next_pend  = SEI_PG_ERASE;
                    next_paddr = next_head[AW-1:0];
                    next_pdata = SEI_ERASED;  // all ones
                  end
                end
                default: begin
                  case (next_head[AW-1 -: 2])
                    SEI_EXT_ENABLE:  next_wen = 1'b1;  // stays until disable
                    SEI_EXT_DISABLE: next_wen = 1'b0;  // blocks programming
                    SEI_EXT_BERASE: begin
                      if (wen) begin
                        next_pend  = SEI_PG_BER;
                        next_pdata = SEI_ERASED;
                      end
                    end
                    default: next_state = SEI_DATA;  // bulk write data
                  endcase
                end
              endcase
            end
          end
          SEI_DATA: begin
            next_shreg = {shreg[SEI_WORD_BITS-2:0], din};  // msb first
            next_cnt   = cnt + 5'h1;
            if (cnt == 5'(SEI_WORD_BITS - 1)) begin
              next_state = SEI_HOLD;
              next_pdata = next_shreg;
              next_paddr = head[AW-1:0];
              if (op == SEI_OP_WRITE) begin
                // protected words refused
                if (wen && (prot_clr || head[AW-1:0] < prot_addr)) begin
                  next_pend = SEI_PG_WRITE;
                end
              end else if (wen && prot_clr) begin
                next_pend = SEI_PG_BWR;  // bulk write only with protection cleared
              end
            end
          end
          SEI_READ: begin
            // output changes only on shift clock rise
            next_dout  = shreg[SEI_WORD_BITS-1];
            next_shreg = {shreg[SEI_WORD_BITS-2:0], 1'b0};
            next_cnt   = cnt + 5'h1;
            if (cnt == 5'(SEI_WORD_BITS)) begin
              next_state = SEI_HOLD;
              next_oen   = 1'b1;
            end
          end
          SEI_HOLD: ;  // extra clocks of dataless instructions absorbed
          default: next_state = SEI_IDLE;
        endcase
      end
    end
  end
  // register all state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state   <= SEI_IDLE;
      pend    <= SEI_PG_NONE;
      prog    <= SEI_PG_NONE;
      head    <= '0;
      shreg   <= '0;
      cnt     <= 5'h0;
      wen     <= 1'b0;  // power up disabled
      paddr   <= '0;
      pdata   <= '0;
      ptime   <= 32'h0;
      dout    <= 1'b0;
      oen     <= 1'b1;
      load_rd <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      state   <= next_state;
      pend    <= next_pend;
      prog    <= next_prog;
      head    <= next_head;
      shreg   <= next_shreg;
      cnt     <= next_cnt;
      wen     <= next_wen;
      paddr   <= next_paddr;
      pdata   <= next_pdata;
      ptime   <= next_ptime;
      dout    <= next_dout;
      oen     <= next_oen;
      load_rd <= next_load_rd;
      cs_prev <= cs;
    end
  end
  assign serial_out      = dout;
  assign serial_out_oe_n = oen;
  // checks
  a_release_low: assert property (@(posedge clk_sys) disable iff (reset)
    !cs |=> serial_out_oe_n) else $error("output driven while select low");
  a_no_prog_off: assert property (@(posedge clk_sys) disable iff (reset)
    (!wen && cs) |=> pend == SEI_PG_NONE || $past(pend) != SEI_PG_NONE)
    else $error("programming queued while disabled");
  a_out_on_edge: assert property (@(posedge clk_sys) disable iff (reset)
    (state == SEI_READ && !sk_rise && !load_rd) |=> $stable(serial_out))
    else $error("read output moved without shift edge");
  a_busy_low: assert property (@(posedge clk_sys) disable iff (reset)
    (prog != SEI_PG_NONE && !serial_out_oe_n && state == SEI_IDLE) |-> !serial_out)
    else $error("ready shown during programming");
  a_prog_on_fall: assert property (@(posedge clk_sys) disable iff (reset)
    ($past(pend) != SEI_PG_NONE && $past(prog) == SEI_PG_NONE && !$past(cs))
    |-> prog == $past(pend)) else $error("programming not started at select fall");
  // the select fall that ends a complete instruction starts the timed cycle
  a_start_on_fall: assert property (@(posedge clk_sys) disable iff (reset)
    (cs_prev && !cs && pend != SEI_PG_NONE && prog == SEI_PG_NONE) |=> prog != SEI_PG_NONE)
    else $error("programming not started by select fall");
  // a read opens with one driven zero ahead of the data
  sequence s_read_open;
    $rose(state == SEI_READ);
  endsequence : s_read_open
  sequence s_dummy_zero;
    !serial_out_oe_n && !serial_out;
  endsequence : s_dummy_zero
  a_read_dummy: assert property (@(posedge clk_sys) disable iff (reset)
    s_read_open |-> s_dummy_zero) else $error("read did not open with a driven zero");
endmodule : sei_port
`default_nettype wire

// [sei_host.sv]
// Purpose: host model driving the serial instruction pins
// Assumes: pins change on falling clk_sys edges, shift clock period 400 ns
// Notes:   shift clock rests low outside frames
`timescale 1ns/1ps
`default_nettype none
module sei_host (
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      chip_select,
  output logic      shift_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  // a released output reads as the inverse, so an undriven pin never passes as data
  logic line;
  assign line = serial_out_oe_n ? ~serial_out : serial_out;
  // idle pins: deselected, clock parked low
  initial begin
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in   = 1'b0;
  end
  // whole system clocks, counted on the falling edge
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : gap
  // one shift period: data set while low, taken at the rise
  task automatic pulse(input logic b);
    serial_in = b;
    gap(4);
    shift_clock = 1'b1;
    gap(4);
    shift_clock = 1'b0;
  endtask : pulse
  // select, then shift n bits msb first
  task automatic send(input logic [31:0] v, input int n);
    chip_select = 1'b1;
    gap(2);
    for (int i = n - 1; i >= 0; i--) begin
      pulse(v[i]);
    end
  endtask : send
  // drop select before any further rise, then rest 300 ns
  task automatic stop();
    chip_select = 1'b0;
    serial_in   = ~serial_in;  // a dropped data line must not look held
    gap(6);
  endtask : stop
  // dummy bit and sixteen data bits, sampled late in the low phase
  task automatic take(output logic [16:0] got);
    for (int i = 16; i >= 0; i--) begin
      gap(3);
      got[i] = line;
      gap(1);
      shift_clock = 1'b1;
      gap(4);
      shift_clock = 1'b0;
    end
  endtask : take
  // reselect and watch busy, then ready, within a bounded wait
  task automatic status(output logic busy, output logic ready);
    chip_select = 1'b1;
    gap(4);
    busy  = line;
    ready = 1'b0;
    for (int i = 0; i < 1000 && ready !== 1'b1; i++) begin
      gap(1);
      ready = line;
    end
    stop();
  endtask : status
endmodule : sei_host
`default_nettype wire

// [test_serial_eeprom_instruction_port.sv]
// Purpose: self checking bench of the serial instruction port
// Assumes: programming cycle shortened to 50 clocks
// Notes:   array starts unknown, so the first scenario erases it
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_instruction_port;
  import sei_pkg::*;
  logic       clk_sys;          // system clock
  logic       reset;            // power up
  logic       chip_select;      // from host
  logic       shift_clock;      // from host
  logic       serial_in;        // from host
  logic       serial_out;       // to host
  logic       serial_out_oe_n;  // output released when high
  logic       protect_clear;    // protection cleared
  logic [7:0] protect_addr;     // first protected word
  int         n_mismatch;       // failed comparisons
  int         tests_run;        // all comparisons
  sei_host host (.clk_sys(clk_sys), .chip_select(chip_select), .shift_clock(shift_clock),
                 .serial_in(serial_in), .serial_out(serial_out),
                 .serial_out_oe_n(serial_out_oe_n));
  sei_port #(.PROG_CYCLES(50), .WORDS(256)) uut (.clk_sys(clk_sys), .reset(reset),
    .chip_select(chip_select), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .protect_clear(protect_clear), .protect_addr(protect_addr));
  // 50 ns system clock
  always #25 clk_sys = ~clk_sys;
  // compare a read frame
  task automatic chk_word(input string what, input logic [16:0] exp, input logic [16:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  // compare a single pin level
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // whole instruction without waiting for programming
  task automatic cmd(input logic [31:0] v, input int n);
    host.send(v, n);
    host.stop();
  endtask : cmd
  // programming instruction, then busy low and ready high
  task automatic pg(input logic [31:0] v, input int n);
    logic b;
    logic r;
    cmd(v, n);
    host.status(b, r);
    chk_bit("busy", 1'b0, b);
    chk_bit("ready", 1'b1, r);
  endtask : pg
  // read one word after lead zeros; dummy zero leads the data
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input int lead);
    logic [16:0] got;
    host.send({1'b1, SEI_OP_READ, a}, 11 + lead);
    host.take(got);
    host.stop();
    chk_word("read", {1'b0, exp}, got);
    chk_bit("released", 1'b1, serial_out_oe_n);
  endtask : rd
  // enable, bulk erase, first and last words read ones
  task automatic t_bulk_erase();
    cmd({1'b1, SEI_OP_EXT, SEI_EXT_ENABLE, 6'h00}, 11);
    pg({1'b1, SEI_OP_EXT, SEI_EXT_BERASE, 6'h00}, 11);
    rd(8'h00, SEI_ERASED, 0);
    rd(8'hFF, SEI_ERASED, 0);
  endtask : t_bulk_erase
  // a fresh power up refuses writes
  task automatic t_powerup();
    reset = 1'b1;
    host.gap(2);
    reset = 1'b0;
    cmd({1'b1, SEI_OP_WRITE, 8'h07, 16'h1234}, 27);
    rd(8'h07, SEI_ERASED, 0);
  endtask : t_powerup
  // write, read back, lead zeros, aborted write
  task automatic t_write();
    cmd({1'b1, SEI_OP_EXT, SEI_EXT_ENABLE, 6'h00}, 11);
    pg({1'b1, SEI_OP_WRITE, 8'h10, 16'hA5C3}, 27);
    rd(8'h10, 16'hA5C3, 0);
    rd(8'h10, 16'hA5C3, 3);
    cmd({1'b1, SEI_OP_WRITE, 8'h10, 9'h000}, 20);
    rd(8'h10, 16'hA5C3, 0);
  endtask : t_write
  // protected word and guarded bulk write
  task automatic t_protect();
    protect_addr = 8'hF0;
    cmd({1'b1, SEI_OP_WRITE, 8'hF0, 16'h1111}, 27);
    rd(8'hF0, SEI_ERASED, 0);
    cmd({1'b1, SEI_OP_EXT, SEI_EXT_BWRITE, 6'h00, 16'h5A5A}, 27);
    rd(8'h10, 16'hA5C3, 0);
    protect_clear = 1'b1;
    pg({1'b1, SEI_OP_EXT, SEI_EXT_BWRITE, 6'h00, 16'h5A5A}, 27);
    rd(8'hFF, 16'h5A5A, 0);
    rd(8'h10, 16'h5A5A, 0);
  endtask : t_protect
  // single erase, then disable blocks erase but not read
  task automatic t_erase_disable();
    pg({1'b1, SEI_OP_ERASE, 8'h20}, 11);
    rd(8'h20, SEI_ERASED, 0);
    rd(8'h21, 16'h5A5A, 0);
    cmd({1'b1, SEI_OP_EXT, SEI_EXT_DISABLE, 6'h00}, 11);
    cmd({1'b1, SEI_OP_ERASE, 8'h21}, 11);
    rd(8'h21, 16'h5A5A, 0);
  endtask : t_erase_disable
  // verdict, printed once
  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // main sequence, inputs move on the falling edge
  initial begin
    clk_sys       = 1'b0;
    reset         = 1'b1;
    protect_clear = 1'b0;
    protect_addr  = 8'hFF;
    n_mismatch    = 0;
    tests_run     = 0;
    host.gap(2);
    reset = 1'b0;
    t_bulk_erase();
    t_powerup();
    t_write();
    t_protect();
    t_erase_disable();
    stop_test();
  end
  // watchdog: the scenarios need well under 20000 clocks
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
endmodule : test_serial_eeprom_instruction_port
`default_nettype wire
